/* File: dv/cas_requester.sv */
// Requester model: control, arithmetic and input/output sections.
// Assumes a free-running sys_clk; all outputs change on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module cas_requester (
  // Clock
  input wire logic sys_clk,
  // Load commands
  output logic ld_operand,
  output logic ld_program,
  output logic ld_buffer,
  // Address sources
  output logic [cas_pkg::ADDR_W-1:0] operand_addr,
  output logic [cas_pkg::ADDR_W-1:0] program_addr,
  output logic [cas_pkg::ADDR_W-1:0] buffer_transfer_counter,
  // Sequence control
  output logic [cas_pkg::NUM_UNITS-1:0] read_drive,
  output logic [cas_pkg::NUM_UNITS-1:0] write_drive,
  output logic [cas_pkg::NUM_UNITS-1:0] ref_done
);
  ////////////////////////////////////////////////////////////////////////////////
  // Quiet bus at time zero
  initial begin
    {ld_operand, ld_program, ld_buffer} = 3'h0;
    operand_addr = 15'h0000;
    program_addr = 15'h0000;
    buffer_transfer_counter = 15'h0000;
    read_drive = 2'h0;
    write_drive = 2'h0;
    ref_done = 2'h0;
  end

  // One-cycle load command with optional release; order is operand, program, buffer
  task automatic load(input logic [2:0] ld, input logic [14:0] oa, pa, ba, input logic [1:0] dn);
    @(negedge sys_clk);
    {ld_operand, ld_program, ld_buffer} = ld;
    operand_addr = oa;
    program_addr = pa;
    buffer_transfer_counter = ba;
    ref_done = dn;
    @(negedge sys_clk);
    {ld_operand, ld_program, ld_buffer} = 3'h0;
    // Released sources show the inverse so stale values cannot pass
    operand_addr = ~oa;
    program_addr = ~pa;
    buffer_transfer_counter = ~ba;
    ref_done = 2'h0;
  endtask

  // Drive phase strobe levels of one unit
  task automatic strobe(input int u, input logic r, input logic w);
    @(negedge sys_clk);
    read_drive[u] = r;
    write_drive[u] = w;
  endtask
endmodule // cas_requester
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench of the core store address select.
// Assumes cas_requester drives all commands on the falling edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk;
  logic rst;
  logic ld_operand, ld_program, ld_buffer;
  logic [14:0] operand_addr, program_addr, buffer_transfer_counter;
  logic [1:0] read_drive, write_drive, ref_done, unit_active;
  logic [1:0][13:0] held_addr;
  logic [1:0][7:0] vdrv_read_sel, vdrv_write_sel, hdrv_read_sel, hdrv_write_sel;
  logic [1:0][15:0] vdiv_sel, hdiv_sel;
  logic [1:0][3:0] quad_sel;
  int errors = 0;
  int n_checks = 0;
  logic [14:0] ea [2] = '{15'h0000, 15'h0000};
  logic act [2] = '{1'b0, 1'b0};
  logic erd [2] = '{1'b0, 1'b0};
  logic ewr [2] = '{1'b0, 1'b0};

  ////////////////////////////////////////////////////////////////////////////////
  // Design and requester
  cas_addr_select uut (.sys_clk(sys_clk), .rst(rst), .ld_operand(ld_operand), .ld_program(ld_program),
    .ld_buffer(ld_buffer), .operand_addr(operand_addr), .program_addr(program_addr),
    .buffer_transfer_counter(buffer_transfer_counter), .read_drive(read_drive),
    .write_drive(write_drive), .ref_done(ref_done), .unit_active(unit_active), .held_addr(held_addr),
    .vdrv_read_sel(vdrv_read_sel), .vdrv_write_sel(vdrv_write_sel), .hdrv_read_sel(hdrv_read_sel),
    .hdrv_write_sel(hdrv_write_sel), .vdiv_sel(vdiv_sel), .hdiv_sel(hdiv_sel), .quad_sel(quad_sel));
  cas_requester rq (.sys_clk(sys_clk), .ld_operand(ld_operand), .ld_program(ld_program),
    .ld_buffer(ld_buffer), .operand_addr(operand_addr), .program_addr(program_addr),
    .buffer_transfer_counter(buffer_transfer_counter), .read_drive(read_drive),
    .write_drive(write_drive), .ref_done(ref_done));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare tasks and the expected-state checker
  task automatic cmp_sel(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_addr(input logic [13:0] got, input logic [13:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_all();
    logic [14:0] a;
    logic on;
    logic [15:0] vd;
    logic [15:0] hd;
    for (int u = 0; u < 2; u++) begin
      a = ea[u];
      on = act[u];
      vd = on ? 16'h0001 << {a[1], a[8], a[7]} : 16'h0000;
      hd = on ? 16'h0001 << {a[2], a[14], a[13]} : 16'h0000;
      cmp_addr(held_addr[u], a[14:1]);
      cmp_sel({15'h0000, unit_active[u]}, {15'h0000, on});
      cmp_sel(vdiv_sel[u], on ? 16'h0001 << a[6:3] : 16'h0000);
      cmp_sel(hdiv_sel[u], on ? 16'h0001 << a[12:9] : 16'h0000);
      cmp_sel(quad_sel[u], on ? 16'h0001 << a[2:1] : 16'h0000);
      cmp_sel(vdrv_read_sel[u], erd[u] ? vd : 16'h0000);
      cmp_sel(vdrv_write_sel[u], ewr[u] ? vd : 16'h0000);
      cmp_sel(hdrv_read_sel[u], erd[u] ? hd : 16'h0000);
      cmp_sel(hdrv_write_sel[u], ewr[u] ? hd : 16'h0000);
    end
  endtask

  // Load with priority operand, program, buffer; optional release pulses
  task automatic do_load(input logic [2:0] ld, input logic [14:0] oa, pa, ba, input logic [1:0] dn);
    logic [14:0] a;
    a = ld[2] ? oa : (ld[1] ? pa : ba);
    rq.load(ld, oa, pa, ba, dn);
    for (int u = 0; u < 2; u++) if (dn[u]) act[u] = 1'b0;
    if (ld != 3'h0) begin
      ea[a[0]] = a;
      act[a[0]] = 1'b1;
    end
    chk_all();
  endtask

  task automatic do_strobe(input int u, input logic r, input logic w);
    rq.strobe(u, r, w);
    @(negedge sys_clk);
    // Strobe level; drivers follow it whenever the unit is held
    erd[u] = r;
    ewr[u] = w;
    chk_all();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic s_table();
    logic [14:0] t [6] = '{15'h0000, 15'h7fff, 15'h7ffe, 15'h0001, 15'h2aaa, 15'h5555};
    for (int i = 0; i < 6; i++) begin
      case (i % 3)
        0: do_load(3'h4, t[i], 15'h0000, 15'h0000, 2'h0);
        1: do_load(3'h2, 15'h0000, t[i], 15'h0000, 2'h0);
        default: do_load(3'h1, 15'h0000, 15'h0000, t[i], 2'h0);
      endcase
      do_strobe(t[i][0], 1'b1, 1'b0);
      do_strobe(t[i][0], 1'b0, 1'b1);
      do_strobe(t[i][0], 1'b0, 1'b0);
    end
  endtask

  // Consecutive strides with read drive held on both units
  task automatic s_sweep();
    do_strobe(0, 1'b1, 1'b0);
    do_strobe(1, 1'b1, 1'b1);
    for (int i = 0; i < 24; i++) begin
      do_load(3'h4, 15'(i * 8), 15'h0000, 15'h0000, 2'h0);
      do_load(3'h2, 15'h0000, 15'(i * 512 + 1), 15'h0000, 2'h0);
    end
    do_strobe(0, 1'b0, 1'b0);
    do_strobe(1, 1'b0, 1'b0);
  endtask

  task automatic s_priority();
    do_load(3'h7, 15'h1234, 15'h4321, 15'h7777, 2'h0);
    do_load(3'h3, 15'h1234, 15'h4321, 15'h7777, 2'h0);
    do_load(3'h4, 15'h7ffe, 15'h0000, 15'h0000, 2'h0);
    do_load(3'h4, 15'h0000, 15'h0000, 15'h0000, 2'h0);
    do_load(3'h2, 15'h0000, 15'h7fff, 15'h0000, 2'h0);
    do_load(3'h2, 15'h0000, 15'h0001, 15'h0000, 2'h0);
  endtask

  task automatic s_release();
    do_load(3'h0, 15'h0000, 15'h0000, 15'h0000, 2'h1);
    do_strobe(0, 1'b1, 1'b1);
    do_strobe(0, 1'b0, 1'b0);
    do_load(3'h1, 15'h0000, 15'h0000, 15'h0010, 2'h1);
    do_load(3'h0, 15'h0000, 15'h0000, 15'h0000, 2'h3);
  endtask

  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    chk_all();
    s_table();
    s_sweep();
    s_priority();
    s_release();
    test_done();
  end
endmodule // tb_top
`default_nettype wire

/* File: logic/cas_addr_select.sv */
// Address select of a two-unit interleaved core store.
// Assumes commands, strobes and sources come from logic on sys_clk.
//
// Overview of operation
// R1: Accept 15-bit addresses 00000 to 77777 octal, 32768 locations.
// R2: Address bit 0 picks even or odd unit; 14 bits load there.
// R3: Two bits above the unit bit pick quadrant; three lowest form octant.
// R4: Next six bits pick vertical driver/diverter, top six horizontal.
// R5: Vertical driver index is bits 1, 8, 7, bit 1 most significant.
// R6: Horizontal driver index is bits 2, 14, 13, bit 2 most significant.
// R7: Vertical diverter steps at 1/8, driver at 1/128 of address rate.
// R8: Horizontal selections follow same order at 1/64 the vertical rate.
// R9: Exactly one of eight drivers, then one of sixteen diverters, per axis.
// R10: One driver pair narrows to 256 locations; diverters pick one.
// R11: Each unit holds a 14-stage address steady during a reference.
// R12: Requesters load via operand, program or buffer counter commands.
// R13: Operand and program loads are forced; no prior clear needed.
// R14: Even unit decodes from first register, odd from second.
// R15: Vertical diverters use stages 3 to 6, horizontal 9 to 12.
// R16: Driver selects qualified by separate read and write drive strobes.
// R17: Selects are one-hot from held address; unaddressed unit shows none.
`timescale 1ns/1ps
`default_nettype none
module cas_addr_select (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Load commands
  input wire logic ld_operand,
  input wire logic ld_program,
  input wire logic ld_buffer,
  // Address sources
  input wire logic [cas_pkg::ADDR_W-1:0] operand_addr,
  input wire logic [cas_pkg::ADDR_W-1:0] program_addr,
  input wire logic [cas_pkg::ADDR_W-1:0] buffer_transfer_counter,
  // Per-unit sequence control
  input wire logic [cas_pkg::NUM_UNITS-1:0] read_drive,
  input wire logic [cas_pkg::NUM_UNITS-1:0] write_drive,
  input wire logic [cas_pkg::NUM_UNITS-1:0] ref_done,
  // Held state
  output logic [cas_pkg::NUM_UNITS-1:0] unit_active,
  output logic [cas_pkg::NUM_UNITS-1:0][cas_pkg::STG_W-1:0] held_addr,
  // Driver selects
  output logic [cas_pkg::NUM_UNITS-1:0][cas_pkg::DRV_N-1:0] vdrv_read_sel,
  output logic [cas_pkg::NUM_UNITS-1:0][cas_pkg::DRV_N-1:0] vdrv_write_sel,
  output logic [cas_pkg::NUM_UNITS-1:0][cas_pkg::DRV_N-1:0] hdrv_read_sel,
  output logic [cas_pkg::NUM_UNITS-1:0][cas_pkg::DRV_N-1:0] hdrv_write_sel,
  // Diverter and quadrant selects
  output logic [cas_pkg::NUM_UNITS-1:0][cas_pkg::DIV_N-1:0] vdiv_sel,
  output logic [cas_pkg::NUM_UNITS-1:0][cas_pkg::DIV_N-1:0] hdiv_sel,
  output logic [cas_pkg::NUM_UNITS-1:0][cas_pkg::QUAD_N-1:0] quad_sel
);

  localparam int NU = cas_pkg::NUM_UNITS;

  logic load_valid;
  logic load_unit;
  logic [cas_pkg::STG_W-1:0] load_stg;

  cas_pkg::cas_unit_state_type state_r [NU];
  cas_pkg::cas_unit_state_type state_nxt [NU];
  logic [NU-1:0][cas_pkg::STG_W-1:0] addr_r;
  logic [NU-1:0][cas_pkg::STG_W-1:0] addr_nxt;
  logic [NU-1:0] active_nxt;
  logic [NU-1:0] load_here;

  logic [NU-1:0][cas_pkg::DRV_N-1:0] vrd_r, vrd_nxt;
  logic [NU-1:0][cas_pkg::DRV_N-1:0] vwr_r, vwr_nxt;
  logic [NU-1:0][cas_pkg::DRV_N-1:0] hrd_r, hrd_nxt;
  logic [NU-1:0][cas_pkg::DRV_N-1:0] hwr_r, hwr_nxt;
  logic [NU-1:0][cas_pkg::DIV_N-1:0] vdiv_r, vdiv_nxt;
  logic [NU-1:0][cas_pkg::DIV_N-1:0] hdiv_r, hdiv_nxt;
  logic [NU-1:0][cas_pkg::QUAD_N-1:0] quad_r, quad_nxt;
  logic [NU-1:0] active_r;

  ////////////////////////////////////////////////////////////////
  // Requester choice; all 15-bit codes are legal addresses
  cas_addr_src u_src ( // [R1] [R12]
    .ld_operand(ld_operand),
    .ld_program(ld_program),
    .ld_buffer(ld_buffer),
    .operand_addr(operand_addr),
    .program_addr(program_addr),
    .buffer_transfer_counter(buffer_transfer_counter),
    .load_valid(load_valid),
    .load_unit(load_unit),
    .load_stg(load_stg)
  );

  ////////////////////////////////////////////////////////////////
  // Per-unit hold state and address next values
  always_comb begin
    for (int u = 0; u < NU; u++) begin
      load_here[u] = load_valid && (load_unit == u[0]); // [R2]
      addr_nxt[u] = addr_r[u];
      state_nxt[u] = state_r[u];
      unique case (state_r[u])
        cas_pkg::UNIT_IDLE: begin
          if (load_here[u]) begin
            state_nxt[u] = cas_pkg::UNIT_HELD;
          end
        end
        cas_pkg::UNIT_HELD: begin
          // Load beats a release in the same cycle
          if (ref_done[u] && !load_here[u]) begin
            state_nxt[u] = cas_pkg::UNIT_IDLE;
          end
        end
      endcase
      // Forced load: every stage overwritten, no clear step
      if (load_here[u]) begin
        addr_nxt[u] = load_stg; // [R13] [R11]
      end
      active_nxt[u] = (state_nxt[u] == cas_pkg::UNIT_HELD);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Translators, one per unit, fed by that unit's next register value only
  for (genvar g = 0; g < NU; g++) begin : g_unit
    cas_unit_decode u_dec ( // [R14] [R9] [R10] [R17]
      .stg(addr_nxt[g]),
      .active(active_nxt[g]),
      .read_drive(read_drive[g]), // [R16]
      .write_drive(write_drive[g]),
      .vdrv_rd(vrd_nxt[g]),
      .vdrv_wr(vwr_nxt[g]),
      .hdrv_rd(hrd_nxt[g]),
      .hdrv_wr(hwr_nxt[g]),
      .vdiv(vdiv_nxt[g]),
      .hdiv(hdiv_nxt[g]),
      .quad(quad_nxt[g])
    );
  end

  ////////////////////////////////////////////////////////////////
  // Register stage: address, state and decoded selects together
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int u = 0; u < NU; u++) begin
        state_r[u] <= cas_pkg::UNIT_IDLE;
        addr_r[u] <= cas_pkg::STG_RESET;
      end
      active_r <= '0;
      vrd_r <= '0;
      vwr_r <= '0;
      hrd_r <= '0;
      hwr_r <= '0;
      vdiv_r <= '0;
      hdiv_r <= '0;
      quad_r <= '0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      active_r <= active_nxt;
      vrd_r <= vrd_nxt;
      vwr_r <= vwr_nxt;
      hrd_r <= hrd_nxt;
      hwr_r <= hwr_nxt;
      vdiv_r <= vdiv_nxt;
      hdiv_r <= hdiv_nxt;
      quad_r <= quad_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs straight from the registers
  assign unit_active = active_r;
  assign held_addr = addr_r;
  assign vdrv_read_sel = vrd_r;
  assign vdrv_write_sel = vwr_r;
  assign hdrv_read_sel = hrd_r;
  assign hdrv_write_sel = hwr_r;
  assign vdiv_sel = vdiv_r;
  assign hdiv_sel = hdiv_r;
  assign quad_sel = quad_r;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  for (genvar g = 0; g < NU; g++) begin : g_chk
    // Loaded address appears in the addressed unit next cycle
    a_unit_load_lands: assert property ( // [R2]
      load_valid && load_unit == g[0] |=> held_addr[g] == $past(load_stg) && unit_active[g])
      else $error("unit register did not take load");

    // Other unit untouched by a load
    a_other_unit_holds: assert property ( // [R14]
      load_valid && load_unit != g[0] |=> $stable(held_addr[g]))
      else $error("load disturbed other unit");

    // Held address steady until next load
    a_addr_held_steady: assert property ( // [R11]
      !(load_valid && load_unit == g[0]) |=> $stable(held_addr[g]))
      else $error("held address moved");

    // Vertical driver index order
    a_vdrv_index_order: assert property ( // [R5]
      vdrv_read_sel[g] != '0 |->
      vdrv_read_sel[g] == cas_pkg::drv_onehot({held_addr[g][0], held_addr[g][7], held_addr[g][6]}))
      else $error("vertical driver index wrong");

    // Horizontal driver index order
    a_hdrv_index_order: assert property ( // [R6]
      hdrv_write_sel[g] != '0 |->
      hdrv_write_sel[g] == cas_pkg::drv_onehot({held_addr[g][1], held_addr[g][13], held_addr[g][12]}))
      else $error("horizontal driver index wrong");

    // Diverters from stages 3-6 and 9-12 while held
    a_div_stage_map: assert property ( // [R15] [R4]
      unit_active[g] |-> vdiv_sel[g] == cas_pkg::div_onehot(held_addr[g][5:2])
      && hdiv_sel[g] == cas_pkg::div_onehot(held_addr[g][11:8]))
      else $error("diverter stage mapping wrong");

    // Quadrant from the two bits above unit select
    a_quad_field: assert property ( // [R3]
      unit_active[g] |-> quad_sel[g] == cas_pkg::quad_onehot(held_addr[g][1:0]))
      else $error("quadrant select wrong");

    // Strobe gates driver one cycle later
    a_strobe_gates_drv: assert property ( // [R16]
      ##1 unit_active[g] |->
      ((vdrv_read_sel[g] != '0) == $past(read_drive[g]))
      && ((vdrv_write_sel[g] != '0) == $past(write_drive[g])))
      else $error("drive strobe gating wrong");

    // Exactly one diverter and at most one read driver per axis when held
    a_onehot_selects: assert property ( // [R9] [R10]
      unit_active[g] |-> $onehot(vdiv_sel[g]) && $onehot(hdiv_sel[g])
      && $onehot0(vdrv_read_sel[g]) && $onehot0(hdrv_read_sel[g]))
      else $error("select not one-hot");

    // Idle unit drives nothing
    a_idle_unit_quiet: assert property ( // [R17]
      !unit_active[g] |-> vdrv_read_sel[g] == '0 && vdrv_write_sel[g] == '0
      && hdrv_read_sel[g] == '0 && hdrv_write_sel[g] == '0
      && vdiv_sel[g] == '0 && hdiv_sel[g] == '0 && quad_sel[g] == '0)
      else $error("idle unit shows a select");

    // Write drivers one of eight as well
    a_write_onehot: assert property ( // [R9]
      $onehot0(vdrv_write_sel[g]) && $onehot0(hdrv_write_sel[g]))
      else $error("write driver not one-hot");

    // Both axes driven together to reach one region
    a_axes_paired: assert property ( // [R10]
      (vdrv_read_sel[g] != '0) == (hdrv_read_sel[g] != '0)
      && (vdrv_write_sel[g] != '0) == (hdrv_write_sel[g] != '0))
      else $error("driver axes not paired");

    // Release without load drops the unit
    a_release_idles: assert property ( // [R11]
      ref_done[g] && !(load_valid && load_unit == g[0]) |=> !unit_active[g])
      else $error("release not honoured");

    // Main scenarios
    c_read_phase: cover property (
      unit_active[g] && read_drive[g] ##1 vdrv_read_sel[g] != '0);
    c_write_phase: cover property (
      unit_active[g] && write_drive[g] ##1 hdrv_write_sel[g] != '0);
    c_load_and_release: cover property (
      load_valid && load_unit == g[0] && ref_done[g]);
  end

  // Buffered load with no other command present
  c_buffer_load: cover property (ld_buffer && !ld_operand && !ld_program);

  // Operand command wins; every stage is overwritten
  a_operand_first: assert property ( // [R13]
    ld_operand |=> held_addr[$past(operand_addr[cas_pkg::UNIT_BIT])]
    == $past(operand_addr[cas_pkg::ADDR_W-1:cas_pkg::STG_LSB]))
    else $error("operand load not taken");

  // Program command wins over the buffer counter
  a_program_second: assert property ( // [R13]
    ld_program && !ld_operand |=> held_addr[$past(program_addr[cas_pkg::UNIT_BIT])]
    == $past(program_addr[cas_pkg::ADDR_W-1:cas_pkg::STG_LSB]))
    else $error("program load not taken");

  // Buffer counter loads only when alone
  a_buffer_last: assert property ( // [R2]
    ld_buffer && !ld_operand && !ld_program
    |=> held_addr[$past(buffer_transfer_counter[cas_pkg::UNIT_BIT])]
    == $past(buffer_transfer_counter[cas_pkg::ADDR_W-1:cas_pkg::STG_LSB]))
    else $error("buffer load not taken");

  // Reset idles both units and clears their stages
  a_reset_clears: assert property (disable iff (1'b0) // [R17]
    rst |=> unit_active == '0 && held_addr[0] == cas_pkg::STG_RESET && held_addr[1] == cas_pkg::STG_RESET)
    else $error("reset left state behind");

  // Stage increments that move a diverter translator by one place
  localparam logic [cas_pkg::STG_W-1:0] VDIV_STEP = 14'h0001 << (cas_pkg::VDIV_STG_LO - cas_pkg::STG_LSB);
  localparam logic [cas_pkg::STG_W-1:0] HDIV_STEP = 14'h0001 << (cas_pkg::HDIV_STG_LO - cas_pkg::STG_LSB);

  // Address step of eight rotates the vertical diverter by one place
  a_vdiv_step: assert property ( // [R7]
    load_valid && !load_unit && unit_active[0] && load_stg == held_addr[0] + VDIV_STEP
    |=> vdiv_sel[0] == {$past(vdiv_sel[0][cas_pkg::DIV_N-2:0]), $past(vdiv_sel[0][cas_pkg::DIV_N-1])})
    else $error("vertical diverter step wrong");

  // Address step of 512 rotates the horizontal diverter by one place
  a_hdiv_step: assert property ( // [R8]
    load_valid && load_unit && unit_active[1] && load_stg == held_addr[1] + HDIV_STEP
    |=> hdiv_sel[1] == {$past(hdiv_sel[1][cas_pkg::DIV_N-2:0]), $past(hdiv_sel[1][cas_pkg::DIV_N-1])})
    else $error("horizontal diverter step wrong");

endmodule // cas_addr_select
`default_nettype wire

/* File: logic/cas_addr_src.sv */
// Source selection for an address load: picks one of three requesters.
// Assumes the load strobes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cas_addr_src (
  // Load commands
  input wire logic ld_operand,
  input wire logic ld_program,
  input wire logic ld_buffer,
  // Address sources
  input wire logic [cas_pkg::ADDR_W-1:0] operand_addr,
  input wire logic [cas_pkg::ADDR_W-1:0] program_addr,
  input wire logic [cas_pkg::ADDR_W-1:0] buffer_transfer_counter,
  // Selected load
  output logic load_valid,
  output logic load_unit,
  output logic [cas_pkg::STG_W-1:0] load_stg
);

  logic [cas_pkg::ADDR_W-1:0] src;

  ////////////////////////////////////////////////////////////////
  // Fixed priority: operand, then program, then buffer
  always_comb begin
    if (ld_operand) begin
      src = operand_addr;
    end else if (ld_program) begin
      src = program_addr;
    end else begin
      src = buffer_transfer_counter;
    end
    load_valid = ld_operand | ld_program | ld_buffer;
    load_unit = src[cas_pkg::UNIT_BIT];
    load_stg = src[cas_pkg::ADDR_W-1:cas_pkg::STG_LSB];
  end

endmodule // cas_addr_src
`default_nettype wire

/* File: logic/cas_pkg.sv */
// Constants and decode helpers for the core store address select.
// Assumes stage n of a unit address register holds address bit n (n = 1..14).
package cas_pkg;

  // Address layout
  localparam int ADDR_W = 15;
  localparam int STG_W = 14;
  localparam int NUM_UNITS = 2;
  localparam int DRV_N = 8;
  localparam int DIV_N = 16;
  localparam int QUAD_N = 4;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 15'h7fff;
  localparam int UNIT_BIT = 0;
  localparam int STG_LSB = 1;
  localparam logic UNIT_EVEN = 1'h0;
  localparam logic UNIT_ODD = 1'h1;
  localparam logic [STG_W-1:0] STG_RESET = 14'h0000;

  // Stage numbers feeding each translator
  localparam int QUAD_STG_HI = 2;
  localparam int QUAD_STG_LO = 1;
  localparam int VDRV_STG_HI = 1;
  localparam int VDRV_STG_MID = 8;
  localparam int VDRV_STG_LO = 7;
  localparam int HDRV_STG_HI = 2;
  localparam int HDRV_STG_MID = 14;
  localparam int HDRV_STG_LO = 13;
  localparam int VDIV_STG_HI = 6;
  localparam int VDIV_STG_LO = 3;
  localparam int HDIV_STG_HI = 12;
  localparam int HDIV_STG_LO = 9;

  // Unit holding state
  typedef enum logic {
    UNIT_IDLE = 1'b0,
    UNIT_HELD = 1'b1
  } cas_unit_state_type;

  // Translator indices from the held stages
  function automatic logic [2:0] vdrv_index(input logic [STG_W-1:0] s);
    return {s[VDRV_STG_HI-STG_LSB], s[VDRV_STG_MID-STG_LSB], s[VDRV_STG_LO-STG_LSB]}; // [R5] [R7]
  endfunction

  function automatic logic [2:0] hdrv_index(input logic [STG_W-1:0] s);
    return {s[HDRV_STG_HI-STG_LSB], s[HDRV_STG_MID-STG_LSB], s[HDRV_STG_LO-STG_LSB]}; // [R6] [R8]
  endfunction

  function automatic logic [3:0] vdiv_index(input logic [STG_W-1:0] s);
    return s[VDIV_STG_HI-STG_LSB:VDIV_STG_LO-STG_LSB]; // [R4] [R15] [R7]
  endfunction

  function automatic logic [3:0] hdiv_index(input logic [STG_W-1:0] s);
    return s[HDIV_STG_HI-STG_LSB:HDIV_STG_LO-STG_LSB]; // [R4] [R15] [R8]
  endfunction

  function automatic logic [1:0] quad_index(input logic [STG_W-1:0] s);
    return s[QUAD_STG_HI-STG_LSB:QUAD_STG_LO-STG_LSB]; // [R3]
  endfunction

  // One-hot expanders
  function automatic logic [DRV_N-1:0] drv_onehot(input logic [2:0] i);
    logic [DRV_N-1:0] r;
    r = '0;
    r[i] = 1'b1;
    return r;
  endfunction

  function automatic logic [DIV_N-1:0] div_onehot(input logic [3:0] i);
    logic [DIV_N-1:0] r;
    r = '0;
    r[i] = 1'b1;
    return r;
  endfunction

  function automatic logic [QUAD_N-1:0] quad_onehot(input logic [1:0] i);
    logic [QUAD_N-1:0] r;
    r = '0;
    r[i] = 1'b1;
    return r;
  endfunction

endpackage

/* File: logic/cas_unit_decode.sv */
// Translators of one storage unit: drivers, diverters and quadrant.
// Assumes the stage value given is the one the unit will hold next.
`timescale 1ns/1ps
`default_nettype none
module cas_unit_decode (
  // Held address and state
  input wire logic [cas_pkg::STG_W-1:0] stg,
  input wire logic active,
  // Drive phase strobes
  input wire logic read_drive,
  input wire logic write_drive,
  // Driver selects
  output logic [cas_pkg::DRV_N-1:0] vdrv_rd,
  output logic [cas_pkg::DRV_N-1:0] vdrv_wr,
  output logic [cas_pkg::DRV_N-1:0] hdrv_rd,
  output logic [cas_pkg::DRV_N-1:0] hdrv_wr,
  // Diverter and quadrant selects
  output logic [cas_pkg::DIV_N-1:0] vdiv,
  output logic [cas_pkg::DIV_N-1:0] hdiv,
  output logic [cas_pkg::QUAD_N-1:0] quad
);

  logic [cas_pkg::DRV_N-1:0] vdrv;
  logic [cas_pkg::DRV_N-1:0] hdrv;

  ////////////////////////////////////////////////////////////////
  // One of eight drivers, gated by phase; one of sixteen diverters
  always_comb begin
    vdrv = active ? cas_pkg::drv_onehot(cas_pkg::vdrv_index(stg)) : '0;
    hdrv = active ? cas_pkg::drv_onehot(cas_pkg::hdrv_index(stg)) : '0;
    vdrv_rd = read_drive ? vdrv : '0;
    vdrv_wr = write_drive ? vdrv : '0;
    hdrv_rd = read_drive ? hdrv : '0;
    hdrv_wr = write_drive ? hdrv : '0;
    vdiv = active ? cas_pkg::div_onehot(cas_pkg::vdiv_index(stg)) : '0;
    hdiv = active ? cas_pkg::div_onehot(cas_pkg::hdiv_index(stg)) : '0;
    quad = active ? cas_pkg::quad_onehot(cas_pkg::quad_index(stg)) : '0;
  end

endmodule // cas_unit_decode
`default_nettype wire
